// ### tpg_pkg.sv
package tpg_pkg;

   // Indirect window in the main register map
   localparam logic [7:0] ADDR_PAGE = 8'hB0;
   localparam logic [7:0] ADDR_OFFS = 8'hB1;
   localparam logic [7:0] ADDR_DATA = 8'hB2;
   localparam logic [7:0] GEN_PAGE  = 8'h00;

   // Offsets inside the generator page
   localparam logic [7:0] OFF_CTL      = 8'h01;
   localparam logic [7:0] OFF_CFG      = 8'h02;
   localparam logic [7:0] OFF_DTVC     = 8'h03;
   localparam logic [7:0] OFF_LBYTES_H = 8'h04;
   localparam logic [7:0] OFF_LBYTES_L = 8'h05;
   localparam logic [7:0] OFF_BARW_H   = 8'h06;
   localparam logic [7:0] OFF_BARW_L   = 8'h07;
   localparam logic [7:0] OFF_ACT_H    = 8'h08;
   localparam logic [7:0] OFF_ACT_L    = 8'h09;
   localparam logic [7:0] OFF_TOT_H    = 8'h0A;
   localparam logic [7:0] OFF_TOT_L    = 8'h0B;
   localparam logic [7:0] OFF_PER_H    = 8'h0C;
   localparam logic [7:0] OFF_PER_L    = 8'h0D;
   localparam logic [7:0] OFF_VBP      = 8'h0E;
   localparam logic [7:0] OFF_VFP      = 8'h0F;
   localparam logic [7:0] OFF_BLK_BASE = 8'h10;
   localparam logic [7:0] OFF_STATUS   = 8'h20;

   // Field positions
   localparam int CTL_ENABLE   = 0;
   localparam int CFG_BARS_LSB = 0;
   localparam int CFG_FIXED    = 2;
   localparam int CFG_ALT      = 3;
   localparam int CFG_BLK_LSB  = 4;
   localparam int DI_VC_LSB    = 6;

   // Reset values
   localparam logic [7:0]  RST_CTL  = 8'h00;
   localparam logic [7:0]  RST_CFG  = 8'h03;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   // Packet constants
   localparam logic [5:0]  DT_FRAME_START = 6'h00;
   localparam logic [5:0]  DT_FRAME_END   = 6'h01;
   localparam logic [15:0] CRC_INIT       = 16'hFFFF;
   localparam logic [15:0] CRC_POLY       = 16'h8408;
   localparam logic [7:0]  BYTE_ALL_ONES  = 8'hFF;
   localparam logic [0:7][7:0] BAR_BYTES  = '{8'hAA, 8'h33, 8'hF0, 8'h7F,
                                              8'h55, 8'hCC, 8'h0F, 8'h80};
   localparam logic [0:5][23:0] ECC_MASKS = '{24'hF1_2CB7, 24'hF2_555B,
                                              24'h74_9A6D, 24'hB8_E38E,
                                              24'hDF_03F0, 24'hEF_FC00};

   // Timing
   localparam int CLK_NS        = 10;
   localparam int UNIT_NS       = 10;
   localparam int UNIT_SLOW_NS  = 20;
   localparam int UNIT_CYC      = (UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int UNIT_SLOW_CYC = (UNIT_SLOW_NS + CLK_NS - 1) / CLK_NS;

   // Output buffer
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_WIDTH = 9;

   typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PAY, ST_CRC} tpg_state_t;

   function automatic logic [7:0] tpg_ecc(input logic [23:0] hdr);
      logic [7:0] e;
      e = 8'h00;
      for (int i = 0; i < 6; i++) begin
         e[i] = ^(hdr & ECC_MASKS[i]);
      end
      return e;
   endfunction : tpg_ecc

   function automatic logic [15:0] tpg_crc(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : tpg_crc

endpackage : tpg_pkg

// ### tpg_fifo.sv
`timescale 1ns/100ps
module tpg_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             clkEn,
   // Fill side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   // Drain side
   output logic                  outValid,
   output logic [WIDTH-1:0]      outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic [WIDTH-1:0]            q;
      logic                        qv;
   } tpg_fifo_state_t;

   tpg_fifo_state_t st_reg, st_next;
   logic push, load;

   // Full is honest: the output stage is extra, so up to DEPTH+1 words are held
   assign inReady  = (st_reg.cnt != (AW+1)'(DEPTH));
   assign outValid = st_reg.qv;
   assign outData  = st_reg.q;

   always_comb begin
      st_next = st_reg;
      push    = inValid && inReady;
      load    = (st_reg.cnt != '0) && (!st_reg.qv || outReady);
      if (push) begin
         st_next.mem[st_reg.wp] = inData;
         st_next.wp             = st_reg.wp + 1'b1;
      end
      if (load) begin
         st_next.q  = st_reg.mem[st_reg.rp];
         st_next.qv = 1'b1;
         st_next.rp = st_reg.rp + 1'b1;
      end else if (outReady) begin
         // Cleared on drain so a stale last flag never shows without valid
         st_next.qv = 1'b0;
         st_next.q  = '0;
      end
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(load);
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else if (clkEn) begin
         st_reg <= st_next;
      end
   end

endmodule : tpg_fifo

// ### tpg_generator.sv
`timescale 1ns/100ps
//Contract
//- Eight bars default: AA 33 F0 7F 55 CC 0F 80
//- Bars equal width; last bar fills line
//- Bar count selectable: 1, 2, 4, 8
//- Programmable data type, VC, line, bar bytes
//- Programmable active and total lines per frame
//- Back porch after FS, front porch before FE
//- Line period unit 10 ns, 20 ns slow rate
//- Builds full CSI-2 packets in transmit domain
//- Fixed mode repeats block, same geometry
//- Fixed mode bars alternate block and inverse
//- Block size up to sixteen bytes, repeats
//- Sixteen byte locations hold block bytes
//- Generator settings live on page zero
module tpg_generator (
   // Clock, reset and clock enable
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       clkEn,
   // Register access from the serial control slave
   input  wire logic       regWr,
   input  wire logic       regRd,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   output logic [7:0]      regRdata,
   output logic            regRdValid,
   // Transmitter rate
   input  wire logic       rateSlow,
   // Packet byte stream to the transmitter
   output logic [7:0]      outData,
   output logic            outLast,
   output logic            outValid,
   input  wire logic       outReady
);

   typedef struct packed {
      logic [7:0]            page;
      logic [7:0]            offs;
      logic [7:0]            ctl;
      logic [7:0]            cfg;
      logic [7:0]            dtvc;
      logic [7:0]            vbp;
      logic [7:0]            vfp;
      logic [15:0]           lineBytes;
      logic [15:0]           barWidth;
      logic [15:0]           actLines;
      logic [15:0]           totLines;
      logic [15:0]           period;
      logic [15:0][7:0]      blk;
      logic [7:0]            rdData;
      logic                  rdValid;
      logic                  running;
      logic [1:0]            unitCnt;
      logic [15:0]           periodCnt;
      logic [15:0]           lineIdx;
      tpg_pkg::tpg_state_t   state;
      logic [1:0]            hdrIdx;
      logic                  crcIdx;
      logic                  isLong;
      logic [7:0]            pktDi;
      logic [15:0]           pktWc;
      logic [15:0]           payCnt;
      logic [15:0]           barCnt;
      logic [2:0]            barIdx;
      logic [3:0]            blkIdx;
      logic [15:0]           crc;
   } tpg_gen_state_t;

   tpg_gen_state_t st_reg, st_next;

   logic       genValid;
   logic [7:0] genByte;
   logic       genLast;
   logic       fifoReady;
   logic [8:0] fifoOut;

   // Register read mux for the generator page
   function automatic logic [7:0] readPage(input tpg_gen_state_t s);
      logic [7:0] v;
      v = 8'h00;
      unique case (s.offs)
         tpg_pkg::OFF_CTL:      v = s.ctl;
         tpg_pkg::OFF_CFG:      v = s.cfg;
         tpg_pkg::OFF_DTVC:     v = s.dtvc;
         tpg_pkg::OFF_LBYTES_H: v = s.lineBytes[15:8];
         tpg_pkg::OFF_LBYTES_L: v = s.lineBytes[7:0];
         tpg_pkg::OFF_BARW_H:   v = s.barWidth[15:8];
         tpg_pkg::OFF_BARW_L:   v = s.barWidth[7:0];
         tpg_pkg::OFF_ACT_H:    v = s.actLines[15:8];
         tpg_pkg::OFF_ACT_L:    v = s.actLines[7:0];
         tpg_pkg::OFF_TOT_H:    v = s.totLines[15:8];
         tpg_pkg::OFF_TOT_L:    v = s.totLines[7:0];
         tpg_pkg::OFF_PER_H:    v = s.period[15:8];
         tpg_pkg::OFF_PER_L:    v = s.period[7:0];
         tpg_pkg::OFF_VBP:      v = s.vbp;
         tpg_pkg::OFF_VFP:      v = s.vfp;
         tpg_pkg::OFF_STATUS:   v = {6'h00, s.state != tpg_pkg::ST_IDLE, s.running};
         default: begin
            if (s.offs[7:4] == tpg_pkg::OFF_BLK_BASE[7:4]) begin
               v = s.blk[s.offs[3:0]];
            end
         end
      endcase
      return v;
   endfunction : readPage

   // Line timing and frame sequence helpers
   logic        unitTick;
   logic        lineTick;
   logic [1:0]  unitLast;
   logic [15:0] perLast;
   logic [15:0] actFirst;
   logic [15:0] actLast;
   logic [15:0] feLine;
   logic [3:0]  barsLast;
   logic        lastBar;
   logic [7:0]  pixByte;
   logic [23:0] hdrWord;

   always_comb begin
      unitLast = rateSlow ? 2'(tpg_pkg::UNIT_SLOW_CYC - 1)
                          : 2'(tpg_pkg::UNIT_CYC - 1);
      unitTick = (st_reg.unitCnt == unitLast);
      perLast  = (st_reg.period == 16'h0000) ? 16'h0000 : st_reg.period - 16'h0001;
      lineTick = unitTick && (st_reg.periodCnt == perLast);
      actFirst = 16'(st_reg.vbp) + 16'h0001;
      actLast  = 16'(st_reg.vbp) + st_reg.actLines;
      feLine   = actLast + 16'(st_reg.vfp) + 16'h0001;
      barsLast = 4'(4'h1 << st_reg.cfg[tpg_pkg::CFG_BARS_LSB +: 2]) - 4'h1;
      lastBar  = ({1'b0, st_reg.barIdx} == barsLast);
      hdrWord  = {st_reg.pktWc, st_reg.pktDi};
      if (st_reg.cfg[tpg_pkg::CFG_FIXED]) begin
         // Inverse only on odd bars, so the even bars show the block as written
         pixByte = st_reg.blk[st_reg.blkIdx]
                   ^ ((st_reg.cfg[tpg_pkg::CFG_ALT] && st_reg.barIdx[0])
                      ? tpg_pkg::BYTE_ALL_ONES : 8'h00);
      end else begin
         pixByte = tpg_pkg::BAR_BYTES[st_reg.barIdx];
      end
   end

   always_comb begin
      st_next  = st_reg;
      genValid = 1'b0;
      genByte  = 8'h00;
      genLast  = 1'b0;

      // Indirect register window
      st_next.rdValid = 1'b0;
      if (regWr) begin
         unique case (regAddr)
            tpg_pkg::ADDR_PAGE: st_next.page = regWdata;
            tpg_pkg::ADDR_OFFS: st_next.offs = regWdata;
            tpg_pkg::ADDR_DATA: begin
               if (st_reg.page == tpg_pkg::GEN_PAGE) begin
                  unique case (st_reg.offs)
                     tpg_pkg::OFF_CTL:      st_next.ctl             = regWdata;
                     tpg_pkg::OFF_CFG:      st_next.cfg             = regWdata;
                     tpg_pkg::OFF_DTVC:     st_next.dtvc            = regWdata;
                     tpg_pkg::OFF_LBYTES_H: st_next.lineBytes[15:8] = regWdata;
                     tpg_pkg::OFF_LBYTES_L: st_next.lineBytes[7:0]  = regWdata;
                     tpg_pkg::OFF_BARW_H:   st_next.barWidth[15:8]  = regWdata;
                     tpg_pkg::OFF_BARW_L:   st_next.barWidth[7:0]   = regWdata;
                     tpg_pkg::OFF_ACT_H:    st_next.actLines[15:8]  = regWdata;
                     tpg_pkg::OFF_ACT_L:    st_next.actLines[7:0]   = regWdata;
                     tpg_pkg::OFF_TOT_H:    st_next.totLines[15:8]  = regWdata;
                     tpg_pkg::OFF_TOT_L:    st_next.totLines[7:0]   = regWdata;
                     tpg_pkg::OFF_PER_H:    st_next.period[15:8]    = regWdata;
                     tpg_pkg::OFF_PER_L:    st_next.period[7:0]     = regWdata;
                     tpg_pkg::OFF_VBP:      st_next.vbp             = regWdata;
                     tpg_pkg::OFF_VFP:      st_next.vfp             = regWdata;
                     default: begin
                        if (st_reg.offs[7:4] == tpg_pkg::OFF_BLK_BASE[7:4]) begin
                           st_next.blk[st_reg.offs[3:0]] = regWdata;
                        end
                     end
                  endcase
               end
            end
            default: ;
         endcase
      end
      if (regRd) begin
         st_next.rdValid = 1'b1;
         unique case (regAddr)
            tpg_pkg::ADDR_PAGE: st_next.rdData = st_reg.page;
            tpg_pkg::ADDR_OFFS: st_next.rdData = st_reg.offs;
            tpg_pkg::ADDR_DATA: st_next.rdData = (st_reg.page == tpg_pkg::GEN_PAGE)
                                                 ? readPage(st_reg) : 8'h00;
            default:            st_next.rdData = 8'h00;
         endcase
      end

      // Line period counter runs free so frame boundaries stay evenly spaced
      st_next.unitCnt = unitTick ? 2'b00 : st_reg.unitCnt + 2'b01;
      if (unitTick) begin
         st_next.periodCnt = lineTick ? 16'h0000 : st_reg.periodCnt + 16'h0001;
      end

      // Frame sequencer: FS, back porch, active, front porch, FE, idle
      if (lineTick) begin
         st_next.lineIdx = (st_reg.lineIdx >= st_reg.totLines - 16'h0001)
                           ? 16'h0000 : st_reg.lineIdx + 16'h0001;
         if (st_reg.lineIdx == 16'h0000) begin
            st_next.running = st_reg.ctl[tpg_pkg::CTL_ENABLE];
         end
         // A line whose predecessor is still draining is skipped, not queued
         if (st_reg.state == tpg_pkg::ST_IDLE) begin
            st_next.hdrIdx = 2'b00;
            st_next.crcIdx = 1'b0;
            st_next.payCnt = 16'h0000;
            st_next.barCnt = 16'h0000;
            st_next.barIdx = 3'b000;
            st_next.blkIdx = 4'h0;
            st_next.crc    = tpg_pkg::CRC_INIT;
            st_next.pktWc  = 16'h0000;
            if (st_reg.lineIdx == 16'h0000) begin
               if (st_reg.ctl[tpg_pkg::CTL_ENABLE]) begin
                  st_next.state  = tpg_pkg::ST_HDR;
                  st_next.isLong = 1'b0;
                  st_next.pktDi  = {st_reg.dtvc[tpg_pkg::DI_VC_LSB +: 2],
                                    tpg_pkg::DT_FRAME_START};
               end
            end else if (st_reg.running) begin
               if (st_reg.lineIdx >= actFirst && st_reg.lineIdx <= actLast) begin
                  st_next.state  = tpg_pkg::ST_HDR;
                  st_next.isLong = 1'b1;
                  st_next.pktDi  = st_reg.dtvc;
                  st_next.pktWc  = st_reg.lineBytes;
               end else if (st_reg.lineIdx == feLine) begin
                  st_next.state  = tpg_pkg::ST_HDR;
                  st_next.isLong = 1'b0;
                  st_next.pktDi  = {st_reg.dtvc[tpg_pkg::DI_VC_LSB +: 2],
                                    tpg_pkg::DT_FRAME_END};
               end
            end
         end
      end

      // Byte emitter, stalls on a full buffer
      if (fifoReady) begin
         unique case (st_reg.state)
            tpg_pkg::ST_IDLE: ;
            tpg_pkg::ST_HDR: begin
               genValid = 1'b1;
               unique case (st_reg.hdrIdx)
                  2'd0: genByte = st_reg.pktDi;
                  2'd1: genByte = st_reg.pktWc[7:0];
                  2'd2: genByte = st_reg.pktWc[15:8];
                  2'd3: genByte = tpg_pkg::tpg_ecc(hdrWord);
               endcase
               st_next.hdrIdx = st_reg.hdrIdx + 2'b01;
               if (st_reg.hdrIdx == 2'd3) begin
                  genLast       = !st_reg.isLong;
                  st_next.state = !st_reg.isLong ? tpg_pkg::ST_IDLE
                                : (st_reg.pktWc == 16'h0000) ? tpg_pkg::ST_CRC
                                : tpg_pkg::ST_PAY;
               end
            end
            tpg_pkg::ST_PAY: begin
               genValid       = 1'b1;
               genByte        = pixByte;
               st_next.crc    = tpg_pkg::tpg_crc(st_reg.crc, pixByte);
               st_next.payCnt = st_reg.payCnt + 16'h0001;
               st_next.blkIdx = (st_reg.blkIdx == st_reg.cfg[tpg_pkg::CFG_BLK_LSB +: 4])
                                ? 4'h0 : st_reg.blkIdx + 4'h1;
               if (!lastBar && st_reg.barCnt >= st_reg.barWidth - 16'h0001) begin
                  st_next.barCnt = 16'h0000;
                  st_next.barIdx = st_reg.barIdx + 3'b001;
               end else begin
                  st_next.barCnt = st_reg.barCnt + 16'h0001;
               end
               if (st_reg.payCnt == st_reg.pktWc - 16'h0001) begin
                  st_next.state = tpg_pkg::ST_CRC;
               end
            end
            tpg_pkg::ST_CRC: begin
               genValid       = 1'b1;
               genByte        = st_reg.crcIdx ? st_reg.crc[15:8] : st_reg.crc[7:0];
               genLast        = st_reg.crcIdx;
               st_next.crcIdx = 1'b1;
               if (st_reg.crcIdx) begin
                  st_next.state = tpg_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_reg       <= '0;
         st_reg.ctl   <= tpg_pkg::RST_CTL;
         st_reg.cfg   <= tpg_pkg::RST_CFG;
         st_reg.crc   <= tpg_pkg::CRC_INIT;
         st_reg.state <= tpg_pkg::ST_IDLE;
      end else if (clkEn) begin
         st_reg <= st_next;
      end
   end

   assign regRdata   = st_reg.rdData;
   assign regRdValid = st_reg.rdValid;
   assign outData    = fifoOut[7:0];
   assign outLast    = fifoOut[8];

   // Buffer absorbs transmitter stalls; the emitter halts when it fills
   tpg_fifo #(
      .WIDTH (tpg_pkg::FIFO_WIDTH),
      .DEPTH (tpg_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .clkEn    (clkEn),
      .inValid  (genValid),
      .inData   ({genLast, genByte}),
      .inReady  (fifoReady),
      .outValid (outValid),
      .outData  (fifoOut),
      .outReady (outReady)
   );

endmodule : tpg_generator

// ### tpg_generator_chk.sv
`timescale 1ns/100ps
module tpg_generator_chk (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rstn,
   input wire logic       clkEn,
   // Registers
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic       regRdValid,
   input wire logic       rateSlow,
   // Stream
   input wire logic [7:0] outData,
   input wire logic       outLast,
   input wire logic       outValid,
   input wire logic       outReady
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic rdTaken;
   assign rdTaken = regRd && clkEn;
   rd_answer_a: assert property (rdTaken |=> regRdValid)
      else $error("read not answered");
   rd_quiet_a: assert property (!rdTaken && clkEn |=> !regRdValid)
      else $error("spurious read valid");
   rd_unmapped_a: assert property (rdTaken
      && (regAddr < tpg_pkg::ADDR_PAGE || regAddr > tpg_pkg::ADDR_DATA)
      |=> regRdata == 8'h00) else $error("unmapped read not zero");
   rdata_hold_a: assert property (!rdTaken |=> $stable(regRdata))
      else $error("read data changed");
   out_hold_a: assert property (outValid && !outReady
      |=> outValid && $stable(outData) && $stable(outLast)) else $error("byte dropped");
   last_valid_a: assert property (outLast |-> outValid)
      else $error("last without valid");
   freeze_out_a: assert property (!clkEn |=> $stable(outValid) && $stable(regRdValid))
      else $error("state moved while frozen");
   reset_idle_a: assert property ($rose(rstn) |-> !outValid && !regRdValid)
      else $error("busy after reset");
   cover property (rdTaken ##1 regRdValid);
   cover property (outValid && outLast && outReady);
   cover property (outValid && !outReady);
   cover property (regWr && regAddr == tpg_pkg::ADDR_DATA && regWdata == 8'h01);
   cover property (rateSlow && outValid && outLast && outReady);
endmodule : tpg_generator_chk

// ### tpg_rx_model.sv
`timescale 1ns/100ps
module tpg_rx_model (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rstn,
   // Packet stream
   input wire logic [7:0] outData,
   input wire logic       outLast,
   input wire logic       outValid,
   output logic           outReady
);
   logic [7:0] rxq[$];
   int         lens[$];
   int         starts[$];
   int         cyc;
   int         cnt;
   logic       inPkt;
   // One stall in four, so the output stage must hold a byte under backpressure
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         outReady <= 1'b0;
         cyc = 0;
         cnt = 0;
         inPkt = 1'b0;
      end else begin
         cyc++;
         if (outValid && !inPkt) begin
            starts.push_back(cyc);
            inPkt = 1'b1;
         end
         if (outValid && outReady) begin
            rxq.push_back(outData);
            cnt++;
            if (outLast) begin
               lens.push_back(cnt);
               cnt = 0;
               inPkt = 1'b0;
            end
         end
         outReady <= (cyc % 4 != 3);
      end
   end
endmodule : tpg_rx_model

// ### tpg_generator_tb.sv
`timescale 1ns/100ps
module tpg_generator_tb;
   localparam int P = 60;
   localparam int ACT = 2;
   localparam int TOT = 8;
   logic clk_sys, rstn, clkEn, regWr, regRd, regRdValid, rateSlow;
   logic outLast, outValid, outReady;
   logic [7:0] regAddr, regWdata, regRdata, outData, cfg, dtvc;
   logic [7:0] blk[16];
   logic [7:0] vals[14];
   logic [15:0] lineB, barW;
   int err_total, comparisons, cycles, seed, idx, len, lineNo, unit;
   tpg_generator u_dut (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .regWr(regWr),
      .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .regRdValid(regRdValid), .rateSlow(rateSlow), .outData(outData),
      .outLast(outLast), .outValid(outValid), .outReady(outReady));
   tpg_rx_model u_rx (.clk_sys(clk_sys), .rstn(rstn), .outData(outData),
      .outLast(outLast), .outValid(outValid), .outReady(outReady));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         err_total++;
         $display("MISMATCH %0t run too long", $time);
         end_of_test();
      end
   end
   task check8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
      end
   endtask : check8
   task checkNum(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         err_total++;
         $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : checkNum
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regWr <= w;
      regRd <= !w;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
      regRd <= 1'b0;
   endtask : bus
   task wr(input logic [7:0] pg, input logic [7:0] off, input logic [7:0] d);
      bus(1'b1, tpg_pkg::ADDR_PAGE, pg);
      bus(1'b1, tpg_pkg::ADDR_OFFS, off);
      bus(1'b1, tpg_pkg::ADDR_DATA, d);
   endtask : wr
   task rd(input logic [7:0] pg, input logic [7:0] off, input logic [7:0] exp);
      bus(1'b1, tpg_pkg::ADDR_PAGE, pg);
      bus(1'b1, tpg_pkg::ADDR_OFFS, off);
      bus(1'b0, tpg_pkg::ADDR_DATA, 8'h00);
      #1;
      check8({7'h00, regRdValid}, 8'h01);
      check8(regRdata, exp);
   endtask : rd
   function automatic logic [7:0] expByte(input int i);
      int bar;
      bar = i / barW;
      if (bar > (1 << cfg[1:0]) - 1) bar = (1 << cfg[1:0]) - 1;
      if (!cfg[2]) return tpg_pkg::BAR_BYTES[bar];
      return blk[i % (cfg[7:4] + 1)] ^ ((cfg[3] && bar[0]) ? 8'hFF : 8'h00);
   endfunction : expByte
   task end_of_test();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      {rstn, regWr, regRd, rateSlow, regAddr, regWdata} = '0;
      clkEn = 1'b1;
      seed = 32'h1f4f;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int o = 1; o < 16; o++) rd(8'h00, 8'(o), (o == 2) ? 8'h03 : 8'h00);
      rd(8'h00, 8'h30, 8'h00);
      wr(8'h01, tpg_pkg::OFF_CFG, 8'h00);
      rd(8'h01, tpg_pkg::OFF_CFG, 8'h00);
      rd(8'h00, tpg_pkg::OFF_CFG, tpg_pkg::RST_CFG);
      bus(1'b0, 8'h40, 8'h00);
      #1 check8(regRdata, 8'h00);
      // Let the last read pulse clear before freezing, or it would stay frozen high
      @(posedge clk_sys) clkEn <= 1'b0;
      bus(1'b0, tpg_pkg::ADDR_DATA, 8'h00);
      #1 check8({7'h00, regRdValid}, 8'h00);
      @(posedge clk_sys) clkEn <= 1'b1;
      $display("Register test done");
      for (int k = 0; k < 6; k++) begin
         lineB = 16'(8 + {$random(seed)} % 13);
         // Frame 4 uses the five-byte block of RAW10, the other fixed frame a random size
         cfg = (k < 4) ? 8'(k) : {(k == 4) ? 4'h4 : 4'($random(seed)), k == 5, 1'b1,
                                  2'($random(seed))};
         barW = lineB >> cfg[1:0];
         dtvc = 8'($random(seed));
         rateSlow <= k[0];
         unit = k[0] ? tpg_pkg::UNIT_SLOW_CYC : tpg_pkg::UNIT_CYC;
         for (int b = 0; b < 16; b++) begin
            blk[b] = 8'($random(seed));
            wr(8'h00, tpg_pkg::OFF_BLK_BASE + 8'(b), blk[b]);
         end
         vals = '{cfg, dtvc, lineB[15:8], lineB[7:0], barW[15:8], barW[7:0], 8'h00,
                  8'(ACT), 8'h00, 8'(TOT), 8'h00, 8'(P), 8'h01, 8'h01};
         for (int o = 0; o < 14; o++) wr(8'h00, tpg_pkg::OFF_CFG + 8'(o), vals[o]);
         rd(8'h00, tpg_pkg::OFF_CFG, cfg);
         u_rx.rxq.delete();
         u_rx.lens.delete();
         u_rx.starts.delete();
         wr(8'h00, tpg_pkg::OFF_CTL, 8'h01);
         for (int n = 0; n < 5000 && u_rx.lens.size() < ACT + 2; n++) @(posedge clk_sys);
         wr(8'h00, tpg_pkg::OFF_CTL, 8'h00);
         repeat (TOT * P * 2) @(posedge clk_sys);
         checkNum(u_rx.lens.size(), ACT + 2);
         idx = 0;
         for (int p = 0; p < ACT + 2; p++) begin
            len = u_rx.lens[p];
            lineNo = (p == 0) ? 0 : (p <= ACT) ? 1 + p : ACT + 3;
            checkNum(u_rx.starts[p] - u_rx.starts[0], lineNo * P * unit);
            if (p == 0 || p == ACT + 1) begin
               checkNum(len, 4);
               check8(u_rx.rxq[idx], {dtvc[7:6], 5'h00, p != 0});
               check8(u_rx.rxq[idx + 1], 8'h00);
            end else begin
               checkNum(len, lineB + 6);
               check8(u_rx.rxq[idx], dtvc);
               check8(u_rx.rxq[idx + 1], lineB[7:0]);
               check8(u_rx.rxq[idx + 2], lineB[15:8]);
               for (int i = 0; i < lineB; i++)
                  check8(u_rx.rxq[idx + 4 + i], expByte(i));
            end
            idx += len;
         end
         $display("Frame %0d done", k);
      end
      end_of_test();
   end
endmodule : tpg_generator_tb
bind tpg_generator tpg_generator_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn),
   .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
   .regRdata(regRdata), .regRdValid(regRdValid), .rateSlow(rateSlow), .outData(outData),
   .outLast(outLast), .outValid(outValid), .outReady(outReady));
